// ### hw/eeprom_rd_pkg.sv
/*
 * Shared constants for the two-wire EEPROM read-side block.
 * Assumes a system clock far faster than the serial clock.
 */
package eeprom_rd_pkg;
	localparam int ADDR_W = 13;
	localparam int PAGE_W = 5;
	localparam int SER_W = 4;
	localparam logic [3:0] TYPE_ARRAY = 4'hA;
	localparam logic [3:0] TYPE_EXTRA = 4'hB;
	localparam logic [1:0] AREA_PAGE = 2'h0;
	localparam logic [1:0] AREA_LOCK = 2'h1;
	localparam logic [1:0] AREA_SERIAL = 2'h2;
	localparam logic [1:0] AREA_SELECT = 2'h3;
	localparam int AREA_LO_BIT = 10;
	localparam int PROT_SEL_BIT = 15;
	localparam logic [3:0] PROT_PAD = 4'h0;
	localparam logic [4:0] SEL_PAD = 5'h00;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [7:0] UNDEF_BYTE = 8'hFF;
	localparam logic [1:0] PHASE_DEV = 2'h0;
	localparam logic [1:0] PHASE_HI = 2'h1;
	localparam logic [1:0] PHASE_LO = 2'h2;
	localparam logic [1:0] PHASE_DATA = 2'h3;
endpackage

// ### hw/sync_edge.sv
/*
 * Two-flop synchroniser for one level from a foreign clock domain.
 * Assumes the source level holds for several destination clocks.
 */
`timescale 1ns/1ns
module sync_edge
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_ff;

	// The first flop is read only by the second one.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			meta_ff <= 1'b1;
			sync_out <= 1'b1;
		end
		else if (clk_en)
		begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule

// ### hw/eeprom_rd.sv
/*
 * Read-side command engine of a two-wire serial EEPROM target: device
 * address decode, address pointer, array, extra page, serial number and
 * register readback. Assumes the storage arrays are loaded elsewhere and
 * exposed as read ports; the bus lines are sampled on clk, and the serial
 * clock pin clocks only link-side copies of the drive, which no output uses.
 */
`timescale 1ns/1ns
// Function
// (R1) Read starts like write, direction bit one
// (R2) After STOP pointer is last address plus one
// (R3) Current read: address, ack, byte at pointer
// (R4) Pointer wraps from last byte to zero
// (R5) Random read: dummy write then repeated start
// (R6) Controller ends random read with nack, stop
// (R7) Acked read byte increments pointer, sends next
// (R8) Sequential read wraps at boundary and continues
// (R9) Extra page: type 1011, area zero, offset
// (R10) Controller stays within the 32-byte page
// (R11) Page write data acked only when unlocked
// (R12) Read-only 128-bit serial number, dummy write
// (R13) One pointer shared by array and serial
// (R14) Serial needs area bits 10, else undefined
// (R15) Serial pointer wraps after sixteenth byte
// (R16) Controller reads whole serial from its start
// (R17) Protection register read when top bit set
// (R18) Protection read: upper zero, lower settings
// (R19) Repeated protection reads return same value
// (R20) Protection unreadable during write cycle
// (R21) Select register read: 1011, area 11
// (R22) Address byte: type, select code, direction
// (R23) Ack only on type and select match
// (R24) Busy write cycle: ignore all, no ack
// (R25) Protection register uses type 1010
// (R26) Drive data open-drain, change after fall
// (R27) After nack release data, await stop
module eeprom_rd #(
	parameter int ADDR_W = eeprom_rd_pkg::ADDR_W
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic scl_clk,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [2:0] select_code_bits,
	input wire logic [3:0] soft_write_protect,
	input wire logic page_locked,
	input wire logic write_busy,
	output logic [ADDR_W-1:0] mem_addr,
	input wire logic [7:0] mem_data,
	output logic [eeprom_rd_pkg::PAGE_W-1:0] page_addr,
	input wire logic [7:0] page_data,
	output logic [eeprom_rd_pkg::SER_W-1:0] serial_addr,
	input wire logic [7:0] serial_data,
	output logic [ADDR_W-1:0] pointer,
	output logic reading
);
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RECV = 6'h02,
		ST_ACK = 6'h04,
		ST_SEND = 6'h08,
		ST_MACK = 6'h10,
		ST_WAIT = 6'h20
	} state_t;

	logic scl_s, sda_s, scl_d_ff, sda_d_ff;
	state_t state_ff;
	logic [2:0] bit_ff;
	logic [7:0] shift_ff;
	logic [1:0] phase_ff;
	logic read_ff;
	logic extra_ff;
	logic ack_ok_ff;
	logic byte_done_ff;
	logic [7:0] addr_hi_ff;
	logic [ADDR_W-1:0] ptr_ff;
	logic [ADDR_W-1:0] sub_ff;
	logic drive_ff;
	logic drive_val_ff;
	logic lk_meta_ff, lk_drive_ff, lk_val_ff;
	logic [7:0] tx_byte;
	logic [7:0] rx_byte;
	logic scl_rise, scl_fall, start_c, stop_c;
	logic [ADDR_W-1:0] nxt_ptr;

	sync_edge u_scl_sync (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
		.async_in(scl_clk), .sync_out(scl_s));
	sync_edge u_sda_sync (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
		.async_in(sda_in), .sync_out(sda_s));

	// Edge history on the synchronised copies only.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end
		else if (clk_en)
		begin
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d_ff;
	assign scl_fall = ~scl_s & scl_d_ff;
	assign start_c = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	assign stop_c = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
	assign rx_byte = {shift_ff[6:0], sda_s};

	// Pointer advance wraps naturally at the top of the array.
	assign nxt_ptr = ptr_ff + {{(ADDR_W-1){1'b0}}, 1'b1}; // R4 R8

	// Byte source chosen by the decoded target of the current transfer.
	always_comb
	begin
		tx_byte = mem_data;
		if (extra_ff)
		begin
			case (addr_hi_ff[3:2])
				eeprom_rd_pkg::AREA_PAGE: tx_byte = page_data; // R9
				eeprom_rd_pkg::AREA_SERIAL: tx_byte = serial_data; // R12
				eeprom_rd_pkg::AREA_SELECT: tx_byte = {eeprom_rd_pkg::SEL_PAD,
					select_code_bits}; // R21
				default: tx_byte = eeprom_rd_pkg::UNDEF_BYTE; // R14
			endcase
		end
		else if (addr_hi_ff[7])
			tx_byte = {eeprom_rd_pkg::PROT_PAD, soft_write_protect}; // R17 R18 R19 R25
	end

	// Protocol sequencer, decoding and acknowledge decisions.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			state_ff <= ST_IDLE;
			bit_ff <= 3'h0;
			shift_ff <= 8'h00;
			phase_ff <= eeprom_rd_pkg::PHASE_DEV;
			read_ff <= 1'b0;
			extra_ff <= 1'b0;
			ack_ok_ff <= 1'b0;
			addr_hi_ff <= 8'h00;
			byte_done_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			if (write_busy)
				state_ff <= ST_IDLE; // R24 R20
			else if (start_c)
			begin
				state_ff <= ST_RECV;
				bit_ff <= 3'h0;
				byte_done_ff <= 1'b0;
				phase_ff <= eeprom_rd_pkg::PHASE_DEV;
			end
			else if (stop_c)
				state_ff <= ST_IDLE;
			else
			begin
				case (state_ff)
					ST_RECV:
						if (scl_rise)
						begin
							shift_ff <= rx_byte;
							bit_ff <= bit_ff + 3'h1;
							if (bit_ff == eeprom_rd_pkg::BIT_LAST)
							begin
								byte_done_ff <= 1'b1;
								ack_ok_ff <= 1'b1;
								case (phase_ff)
									eeprom_rd_pkg::PHASE_DEV:
									begin
										read_ff <= rx_byte[0]; // R1 R22
										extra_ff <= rx_byte[7:4] == eeprom_rd_pkg::TYPE_EXTRA;
										ack_ok_ff <= rx_byte[3:1] == select_code_bits &&
											(rx_byte[7:4] == eeprom_rd_pkg::TYPE_EXTRA ||
											rx_byte[7:4] == eeprom_rd_pkg::TYPE_ARRAY); // R23
									end
									eeprom_rd_pkg::PHASE_HI: addr_hi_ff <= rx_byte; // R5
									eeprom_rd_pkg::PHASE_DATA:
										ack_ok_ff <= !(extra_ff &&
											addr_hi_ff[3:2] == eeprom_rd_pkg::AREA_PAGE &&
											page_locked); // R11
									default: ;
								endcase
							end
						end
						else if (scl_fall && byte_done_ff)
						begin
							// The acknowledge slot opens only once the clock is low, so the
							// data line never moves while the clock is high.
							state_ff <= ST_ACK; // R26
							byte_done_ff <= 1'b0;
						end
					ST_ACK:
						if (scl_fall && sda_oe)
						begin
							// Enter data output or keep receiving address or write data bytes.
							if (phase_ff == eeprom_rd_pkg::PHASE_DEV && read_ff)
								state_ff <= ST_SEND; // R3
							else
							begin
								state_ff <= ST_RECV;
								if (phase_ff != eeprom_rd_pkg::PHASE_DATA)
									phase_ff <= phase_ff + 2'h1;
							end
							shift_ff <= tx_byte;
							bit_ff <= 3'h0;
						end
						else if (scl_fall)
							state_ff <= ST_WAIT; // R23
					ST_SEND:
						if (scl_fall)
						begin
							shift_ff <= {shift_ff[6:0], 1'b1}; // R26
							bit_ff <= bit_ff + 3'h1;
							if (bit_ff == eeprom_rd_pkg::BIT_LAST)
							begin
								state_ff <= ST_MACK;
								ack_ok_ff <= 1'b0;
							end
						end
					ST_MACK:
						if (scl_rise && sda_s)
							state_ff <= ST_WAIT; // R27
						else if (scl_rise)
							ack_ok_ff <= 1'b1; // R7
						else if (scl_fall && ack_ok_ff)
						begin
							// The next byte is loaded on the fall, after the pointer moved.
							state_ff <= ST_SEND; // R7
							shift_ff <= tx_byte;
							bit_ff <= 3'h0;
						end
					ST_WAIT: ;
					ST_IDLE: ;
					default: state_ff <= ST_IDLE;
				endcase
			end
		end
	end

	// Shared pointer: set by address bytes, advanced per byte sent.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			ptr_ff <= '0;
			sub_ff <= '0;
		end
		else if (clk_en && !write_busy)
		begin
			if (state_ff == ST_RECV && scl_rise && bit_ff == eeprom_rd_pkg::BIT_LAST &&
				phase_ff == eeprom_rd_pkg::PHASE_LO)
				ptr_ff <= ADDR_W'({addr_hi_ff, rx_byte}); // R5 R12 R13
			else if (state_ff == ST_MACK && scl_rise && !sda_s)
				ptr_ff <= nxt_ptr; // R7 R8 R15
			else if (stop_c && state_ff != ST_IDLE && sub_ff == ptr_ff)
				ptr_ff <= nxt_ptr; // R2
			if (state_ff == ST_MACK && scl_rise)
				sub_ff <= ptr_ff;
		end
	end

	// Data line drive, computed on clk and handed to the link domain.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			drive_ff <= 1'b0;
			drive_val_ff <= 1'b1;
		end
		else if (clk_en)
		begin
			drive_ff <= (state_ff == ST_ACK && ack_ok_ff && !write_busy) ||
				(state_ff == ST_SEND && !shift_ff[7]); // R26 R24
			drive_val_ff <= 1'b0;
		end
	end

	// Link side: drive copies retimed on the falling serial clock, read by no output.
	always_ff @(negedge scl_clk)
	begin
		lk_meta_ff <= drive_ff;
		lk_drive_ff <= lk_meta_ff;
		lk_val_ff <= drive_val_ff;
	end

	// Outputs from flops in the main domain keep reset values defined.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			sda_oe <= 1'b0;
			sda_out <= 1'b1;
			pointer <= '0;
			reading <= 1'b0;
			mem_addr <= '0;
			page_addr <= '0;
			serial_addr <= '0;
		end
		else if (clk_en)
		begin
			sda_oe <= drive_ff & ~write_busy; // R24
			sda_out <= 1'b0;
			pointer <= ptr_ff;
			reading <= state_ff == ST_SEND || state_ff == ST_MACK;
			mem_addr <= ptr_ff;
			page_addr <= ptr_ff[eeprom_rd_pkg::PAGE_W-1:0]; // R9 R10
			serial_addr <= ptr_ff[eeprom_rd_pkg::SER_W-1:0]; // R15
		end
	end

	chk_busy_no_ack: assert property (@(posedge clk) disable iff (!reset_n)
		$past(write_busy) && write_busy |-> !sda_oe) // R24
		else $error("data driven during write cycle");
	chk_nack_release: assert property (@(posedge clk) disable iff (!reset_n)
		state_ff == ST_WAIT |=> ##1 !sda_oe) // R27
		else $error("data held after nack");
	chk_ptr_advance: assert property (@(posedge clk) disable iff (!reset_n)
		clk_en && !write_busy && !start_c && !stop_c && state_ff == ST_MACK && scl_rise && !sda_s
		|=> ptr_ff == $past(nxt_ptr)) // R7
		else $error("pointer not advanced on ack");
	chk_nomatch_quiet: assert property (@(posedge clk) disable iff (!reset_n)
		state_ff == ST_ACK && !ack_ok_ff |=> !drive_ff) // R23
		else $error("ack on mismatched address");
	chk_mack_release: assert property (@(posedge clk) disable iff (!reset_n)
		state_ff == ST_MACK |=> !drive_ff) // R26
		else $error("data held in controller acknowledge");
	chk_ack_window: assert property (@(posedge clk) disable iff (!reset_n)
		state_ff == ST_RECV && !byte_done_ff && !start_c |=> state_ff != ST_ACK) // R26
		else $error("acknowledge slot opened early");
	chk_prot_upper: assert property (@(posedge clk) disable iff (!reset_n)
		!extra_ff && addr_hi_ff[7] |-> tx_byte[7:4] == 4'h0) // R18
		else $error("protection upper bits not zero");
	chk_select_read: assert property (@(posedge clk) disable iff (!reset_n)
		extra_ff && addr_hi_ff[3:2] == 2'h3 |-> tx_byte[2:0] == select_code_bits) // R21
		else $error("select readback wrong");
	chk_send_gate: assert property (@(posedge clk) disable iff (!reset_n)
		state_ff == ST_RECV |=> !drive_ff || $past(state_ff) != ST_RECV) // R26
		else $error("drive while receiving");
	chk_read_enter: assert property (@(posedge clk) disable iff (!reset_n)
		clk_en && !write_busy && !start_c && !stop_c && state_ff == ST_ACK && scl_fall
		&& sda_oe && phase_ff == 2'h0 && read_ff |=> state_ff == ST_SEND) // R3
		else $error("read not entered");
endmodule

// ### verification/i2c_ctl_model.sv
/*
 * Behavioural two-wire bus controller that faces the EEPROM read block.
 * Assumes an open-drain data line with a pull-up, resolved by the bench.
 */
`timescale 1ns/1ns
module i2c_ctl_model #(
	parameter int Q = 16
)
(
	input wire logic lclk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_drv
);
	// Both lines idle high, so the serial clock stands still between frames.
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// Quarter bit times are long so the target's two-flop sampling keeps up.
	task automatic tick(input int n);
		repeat (n) @(posedge lclk);
	endtask
	// One bit: data moves while the clock is low and is sampled high.
	task automatic bit_io(input logic b, output logic s);
		tick(Q);
		sda_drv <= b;
		tick(Q);
		scl <= 1'b1;
		tick(Q);
		s = sda_line;
		tick(Q);
		scl <= 1'b0;
	endtask
	// Start or repeated start: data falls while the clock is high.
	task automatic start();
		tick(Q);
		sda_drv <= 1'b1;
		tick(Q);
		scl <= 1'b1;
		tick(Q);
		sda_drv <= 1'b0;
		tick(Q);
		scl <= 1'b0;
	endtask
	// Stop: data rises while the clock is high, then the bus is left idle.
	task automatic stop();
		tick(Q);
		sda_drv <= 1'b0;
		tick(Q);
		scl <= 1'b1;
		tick(Q);
		sda_drv <= 1'b1;
		tick(Q);
	endtask
	// Sends a byte MSB first and returns whether the target acknowledged.
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	// Receives a byte; a withheld acknowledge ends the transfer.
	task automatic rd_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(~ack, s);
	endtask
endmodule

// ### verification/tb_serial_eeprom_read_ops.sv
/*
 * Self-checking bench for the EEPROM read block with its bus controller.
 * Assumes storage read ports are plain patterns derived from the address.
 */
`timescale 1ns/1ns
module tb_serial_eeprom_read_ops;
	localparam logic [3:0] TA = eeprom_rd_pkg::TYPE_ARRAY;
	localparam logic [3:0] TB = eeprom_rd_pkg::TYPE_EXTRA;
	logic clk = 1'b0;
	logic lclk = 1'b0;
	logic reset_n = 1'b0;
	logic scl, sda_drv, sda_line, sda_out, sda_oe, page_locked, write_busy, reading;
	logic [2:0] sel = 3'h5;
	logic [3:0] prot_bits = 4'h0;
	logic [eeprom_rd_pkg::ADDR_W-1:0] mem_addr, pointer;
	logic [eeprom_rd_pkg::PAGE_W-1:0] page_addr;
	logic [eeprom_rd_pkg::SER_W-1:0] serial_addr;
	int err_total = 0;
	int n_compared = 0;
	int cycles = 0;
	// Two unrelated clocks: system and the controller's time base.
	always #50 clk = ~clk;
	always #16 lclk = ~lclk;
	// Wired-AND of the controller and the target's pull-down.
	assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
	function automatic logic [7:0] mem_val(input logic [12:0] a);
		return a[7:0] ^ {3'h0, a[12:8]};
	endfunction
	i2c_ctl_model ctl (.lclk(lclk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
	eeprom_rd #(.ADDR_W(eeprom_rd_pkg::ADDR_W)) DUT (.clk(clk), .reset_n(reset_n),
		.clk_en(1'b1), .scl_clk(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
		.select_code_bits(sel), .soft_write_protect(prot_bits), .page_locked(page_locked),
		.write_busy(write_busy), .mem_addr(mem_addr), .mem_data(mem_val(mem_addr)),
		.page_addr(page_addr), .page_data({3'h5, page_addr}), .serial_addr(serial_addr),
		.serial_data({4'hC, serial_addr}), .pointer(pointer), .reading(reading));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic send(input logic [7:0] b, input logic ack_exp);
		logic ack;
		ctl.wr_byte(b, ack);
		check("ack", {15'h0000, ack}, {15'h0000, ack_exp});
	endtask
	// Dummy write sets the pointer, then a repeated start turns to reading.
	task automatic point(input logic [3:0] typ, input logic [15:0] a);
		ctl.start();
		send({typ, sel, 1'b0}, 1'b1);
		send(a[15:8], 1'b1);
		send(a[7:0], 1'b1);
		ctl.start();
		send({typ, sel, 1'b1}, 1'b1);
	endtask
	task automatic get(input logic [7:0] exp, input logic last);
		logic [7:0] d;
		ctl.rd_byte(!last, d);
		check("data", {8'h00, d}, {8'h00, exp});
		if (last)
			ctl.stop();
	endtask
	// Guards against a hung handshake; the run needs about 8300 cycles.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			err_total++;
			results();
		end
	end
	// Main sequence of bus transfers.
	initial
	begin
		page_locked = 1'b0;
		write_busy = 1'b0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		point(TA, 16'h1FFF);
		get(mem_val(13'h1FFF), 1'b0);
		get(mem_val(13'h0000), 1'b1);
		repeat (4) @(posedge clk);
		check("pointer", {3'h0, pointer}, 16'h0001);
		ctl.start();
		send({TA, sel, 1'b1}, 1'b1);
		get(mem_val(13'h0001), 1'b1);
		ctl.start();
		send({TA, ~sel, 1'b1}, 1'b0);
		ctl.stop();
		@(posedge clk) write_busy <= 1'b1;
		ctl.start();
		send({TA, sel, 1'b1}, 1'b0);
		ctl.stop();
		@(posedge clk) write_busy <= 1'b0;
		@(posedge clk) prot_bits <= 4'hA;
		point(TA, 16'h8000);
		get(8'h0A, 1'b0);
		get(8'h0A, 1'b1);
		point(TB, 16'h0C00);
		get({5'h00, sel}, 1'b1);
		point(TB, 16'h080E);
		get(8'hCE, 1'b0);
		get(8'hCF, 1'b0);
		get(8'hC0, 1'b1);
		point(TB, 16'h001E);
		get(8'hBE, 1'b0);
		get(8'hBF, 1'b1);
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clk) page_locked <= k[0];
			ctl.start();
			send({TB, sel, 1'b0}, 1'b1);
			send(8'h00, 1'b1);
			send(8'h00, 1'b1);
			send(8'hA5, !k[0]);
			ctl.stop();
		end
		results();
	end
endmodule
